/* File: src/terg_pkg.sv */
// Constants, types and layouts of the timer event request gating block
// Notes on behaviour
// (RQ1) Bit 14 enables trigger DMA requests
// (RQ2) Bit 13 enables commutation DMA requests
// (RQ3) Bits 12..9 enable channel 4..1 DMA requests
// (RQ4) Bit 8 enables update DMA requests
// (RQ5) Bit 7 enables brake interrupt
// (RQ6) Bit 6 enables trigger interrupt
// (RQ7) Bit 5 enables commutation interrupt
// (RQ8) Bits 4..1 enable channel 4..1 interrupts
// (RQ9) Bit 0 enables update interrupt
// (RQ10) Channel 1 over-capture flag: input recapture, write-0 clears
// (RQ11) Channels 4..2 over-capture flags, bits 12..10, reset 0
// (RQ12) Brake flag set by valid brake input
// (RQ13) Trigger flag: valid edge, either edge when gated
// (RQ14) Commutation flag set on commutation event
// (RQ15) Capture flag set; cleared by write or read
// (RQ16) Interrupt when flag and enable; DMA gated
// (RQ17) Write 1 keeps flag; reserved zero; enables reset
package terg_pkg;

  // Register bus widths and byte offsets
  localparam int unsigned TERG_AW        = 8;
  localparam int unsigned TERG_DW        = 16;
  localparam logic [7:0]  TERG_OFS_EN    = 8'h0C;
  localparam logic [7:0]  TERG_OFS_STAT  = 8'h10;

  // Number of compare/capture channels
  localparam int unsigned TERG_NUM_CH    = 4;

  // Enable register field positions
  localparam int unsigned TERG_EN_UPD_IRQ  = 0;
  localparam int unsigned TERG_EN_CH_IRQ   = 1;
  localparam int unsigned TERG_EN_COM_IRQ  = 5;
  localparam int unsigned TERG_EN_TRG_IRQ  = 6;
  localparam int unsigned TERG_EN_BRK_IRQ  = 7;
  localparam int unsigned TERG_EN_UPD_DMA  = 8;
  localparam int unsigned TERG_EN_CH_DMA   = 9;
  localparam int unsigned TERG_EN_COM_DMA  = 13;
  localparam int unsigned TERG_EN_TRG_DMA  = 14;

  // Status register field positions
  localparam int unsigned TERG_ST_UPD      = 0;
  localparam int unsigned TERG_ST_CH       = 1;
  localparam int unsigned TERG_ST_COM      = 5;
  localparam int unsigned TERG_ST_TRG      = 6;
  localparam int unsigned TERG_ST_BRK      = 7;
  localparam int unsigned TERG_ST_OVC      = 9;

  // Implemented bits and values after reset
  localparam logic [15:0] TERG_EN_MASK     = 16'h7FFF;
  localparam logic [15:0] TERG_STAT_MASK   = 16'h1EFF;
  localparam logic [15:0] TERG_EN_RST      = 16'h0000;
  localparam logic [7:0]  TERG_FLAG_RST    = 8'h00;
  localparam logic [3:0]  TERG_OVC_RST     = 4'h0;

  // Slave mode codes of the counter controller
  typedef enum logic [2:0] {
    TERG_SM_OFF     = 3'b000,
    TERG_SM_ENC1    = 3'b001,
    TERG_SM_ENC2    = 3'b010,
    TERG_SM_ENC3    = 3'b011,
    TERG_SM_RESET   = 3'b100,
    TERG_SM_GATED   = 3'b101,
    TERG_SM_TRIGGER = 3'b110,
    TERG_SM_EXTCLK  = 3'b111
  } terg_slave_mode_t;

  // Register port request
  typedef struct packed {
    logic [TERG_AW-1:0] addr;
    logic [TERG_DW-1:0] wdata;
    logic               wr;
    logic               rd;
  } terg_bus_req_t;

  // One bit per timer event except brake; also carries DMA requests
  typedef struct packed {
    logic       trig;
    logic       commut;
    logic [3:0] ch;
    logic       update;
  } terg_event_t;

endpackage

/* File: src/terg_rst_sync.sv */
// Reset release synchroniser of the event request gating block
`timescale 1ns/10ps
module terg_rst_sync (
  // Clock and raw reset
  input  wire logic clk_i,
  input  wire logic rstn_i,
  // Synchronised reset
  output logic      rst_n_o
);

  typedef struct packed {
    logic meta;
    logic held;
  } terg_sync_state_t;

  terg_sync_state_t st;
  terg_sync_state_t next_st;

  always_comb begin
    next_st      = st;
    next_st.meta = 1'b1;
    next_st.held = st.meta;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rst_n_o = st.held;

endmodule

/* File: src/terg_gating.sv */
// Event flags, interrupt and DMA request gating of an advanced timer
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/10ps
module terg_gating
  import terg_pkg::*;
#(
  parameter int unsigned AW = terg_pkg::TERG_AW
) (
  // Clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      rstn_i,
  // Register port
  input  wire terg_pkg::terg_bus_req_t   bus_i,
  output logic [terg_pkg::TERG_DW-1:0]   rdata_o,
  // Event sources
  input  wire terg_pkg::terg_event_t     evt_i,
  input  wire logic [3:0]                ch_input_mode_i,
  input  wire logic [3:0]                cap_read_i,
  input  wire logic                      trigger_input_i,
  input  wire terg_pkg::terg_slave_mode_t slave_mode_i,
  input  wire logic                      brake_valid_i,
  // Requests
  output logic                           irq_o,
  output terg_pkg::terg_event_t          dma_req_o
);

  import terg_pkg::*;

  if (AW < 5 || AW > TERG_AW) begin : g_bad_aw
    $error("terg_gating: AW must lie between 5 and 8");
  end

  typedef struct packed {
    logic [15:0]  enable;
    logic [7:0]   flag;
    logic [3:0]   ovc;
    logic         trig_prev;
    logic [15:0]  rdata;
    terg_event_t  dma;
    logic         irq;
  } terg_state_t;

  terg_state_t st;
  terg_state_t next_st;
  logic        rst_n;

  // Sticky flag update: a set in the same cycle beats the clear
  function automatic logic [7:0] sticky8(
    input logic [7:0] cur,
    input logic [7:0] set,
    input logic [7:0] clr
  );
    sticky8 = (cur & ~clr) | set;
  endfunction

  function automatic logic [3:0] sticky4(
    input logic [3:0] cur,
    input logic [3:0] set,
    input logic [3:0] clr
  );
    sticky4 = (cur & ~clr) | set;
  endfunction

  // Address compare on the implemented address bits
  function automatic logic hit(
    input logic [AW-1:0] addr,
    input logic [7:0]    ofs
  );
    hit = (addr == ofs[AW-1:0]);
  endfunction

  // Status register image as software sees it
  function automatic logic [15:0] status_image(
    input logic [7:0] flag,
    input logic [3:0] ovc
  );
    logic [15:0] img;
    img = 16'h0000;
    img[TERG_ST_BRK:TERG_ST_UPD] = flag;
    img[TERG_ST_OVC +: 4] = ovc;
    status_image = img & TERG_STAT_MASK;
  endfunction

  terg_rst_sync u_rst_sync (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .rst_n_o (rst_n)
  );

  // Decoded bus accesses
  logic [AW-1:0] addr;
  logic          wr_en;
  logic          wr_stat;
  logic          rd_en;
  logic          rd_stat;

  assign addr    = bus_i.addr[AW-1:0];
  assign wr_en   = bus_i.wr && hit(addr, TERG_OFS_EN);
  assign wr_stat = bus_i.wr && hit(addr, TERG_OFS_STAT);
  assign rd_en   = bus_i.rd && hit(addr, TERG_OFS_EN);
  assign rd_stat = bus_i.rd && hit(addr, TERG_OFS_STAT);

  // Event detection
  logic       trig_edge;
  logic       trig_rise;
  logic       trig_any;
  logic [3:0] cap_evt;
  logic [3:0] ch_flag;
  logic [3:0] ovc_set;
  logic [3:0] cap_clr;
  terg_event_t evt_now;

  assign trig_rise = trigger_input_i & ~st.trig_prev;
  assign trig_any  = trigger_input_i ^ st.trig_prev;
  assign trig_edge = (slave_mode_i == TERG_SM_GATED) ? trig_any
                                                     : trig_rise; // [RQ13]

  assign ch_flag = st.flag[TERG_ST_CH +: 4];
  assign cap_evt = evt_i.ch & ch_input_mode_i;
  assign ovc_set = cap_evt & ch_flag;                 // [RQ10] [RQ11]
  assign cap_clr = cap_read_i & ch_input_mode_i;      // [RQ15]

  always_comb begin
    evt_now        = evt_i;
    evt_now.trig   = trig_edge;
  end

  // Flag sources and clears
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  logic [3:0] ovc_clr;

  always_comb begin
    flag_set = 8'h00;
    flag_set[TERG_ST_UPD]      = evt_now.update;
    flag_set[TERG_ST_CH +: 4]  = evt_now.ch;          // [RQ15]
    flag_set[TERG_ST_COM]      = evt_now.commut;      // [RQ14]
    flag_set[TERG_ST_TRG]      = evt_now.trig;        // [RQ13]
    flag_set[TERG_ST_BRK]      = brake_valid_i;       // [RQ12]

    flag_clr = 8'h00;
    if (wr_stat) begin
      // Zero clears, one leaves the flag alone
      flag_clr = ~bus_i.wdata[TERG_ST_BRK:TERG_ST_UPD]; // [RQ17]
    end
    flag_clr[TERG_ST_CH +: 4] = flag_clr[TERG_ST_CH +: 4]
                                | cap_clr;            // [RQ15]

    ovc_clr = 4'h0;
    if (wr_stat) begin
      ovc_clr = ~bus_i.wdata[TERG_ST_OVC +: 4];       // [RQ10] [RQ11]
    end
  end

  // DMA request gating
  terg_event_t dma_en;

  always_comb begin
    dma_en        = '0;
    dma_en.update = st.enable[TERG_EN_UPD_DMA];      // [RQ4]
    dma_en.ch     = st.enable[TERG_EN_CH_DMA +: 4];  // [RQ3]
    dma_en.commut = st.enable[TERG_EN_COM_DMA];      // [RQ2]
    dma_en.trig   = st.enable[TERG_EN_TRG_DMA];      // [RQ1]
  end

  // Interrupt enables in status layout, no loop through next_st
  function automatic logic [7:0] irq_enables(
    input logic [15:0] en
  );
    logic [7:0] m;
    m = 8'h00;
    m[TERG_ST_UPD]     = en[TERG_EN_UPD_IRQ];         // [RQ9]
    m[TERG_ST_CH +: 4] = en[TERG_EN_CH_IRQ +: 4];     // [RQ8]
    m[TERG_ST_COM]     = en[TERG_EN_COM_IRQ];         // [RQ7]
    m[TERG_ST_TRG]     = en[TERG_EN_TRG_IRQ];         // [RQ6]
    m[TERG_ST_BRK]     = en[TERG_EN_BRK_IRQ];         // [RQ5]
    irq_enables = m;
  endfunction

  // Next state
  always_comb begin
    next_st = st;

    // Enable register, reserved bit stays zero
    if (wr_en) begin
      next_st.enable = bus_i.wdata & TERG_EN_MASK;   // [RQ17]
    end

    next_st.flag = sticky8(st.flag, flag_set, flag_clr);
    next_st.ovc  = sticky4(st.ovc, ovc_set, ovc_clr);
    next_st.trig_prev = trigger_input_i;

    // One-cycle DMA pulses for enabled events
    next_st.dma = evt_now & dma_en;                  // [RQ16]

    // Level interrupt aligned with the registered flags
    next_st.irq = |(next_st.flag
                    & irq_enables(next_st.enable));  // [RQ16]

    // Read data stand only in the cycle after the strobe
    next_st.rdata = 16'h0000;
    if (rd_en) begin
      next_st.rdata = st.enable & TERG_EN_MASK;
    end else if (rd_stat) begin
      next_st.rdata = status_image(st.flag, st.ovc); // [RQ17]
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st           <= '0;
      st.enable    <= TERG_EN_RST;                   // [RQ17]
      st.flag      <= TERG_FLAG_RST;
      st.ovc       <= TERG_OVC_RST;                  // [RQ11]
    end else begin
      st <= next_st;
    end
  end

  assign rdata_o   = st.rdata;
  assign irq_o     = st.irq;
  assign dma_req_o = st.dma;

endmodule

/* File: test/terg_sink.sv */
// Request sink standing in for the DMA controller
`timescale 1ns/10ps
module terg_sink
  import terg_pkg::*;
(
  // Clock and requests
  input  wire logic                 clk_i,
  input  wire terg_pkg::terg_event_t req_i,
  // Count of update transfers
  output int                        n_upd_o
);
  int count = 0;
  assign n_upd_o = count;
  // One pulse is one transfer
  always @(posedge clk_i) if (req_i.update) count <= count + 1;
endmodule

/* File: test/terg_checker.sv */
// Port-level assertions of the event request gating block
`timescale 1ns/10ps
module terg_checker
  import terg_pkg::*;
(
  // Clock and reset
  input wire logic                      clk_i,
  input wire logic                      rstn_i,
  // Watched ports
  input wire terg_pkg::terg_bus_req_t   bus_i,
  input wire logic [TERG_DW-1:0]        rdata_o,
  input wire terg_pkg::terg_event_t     evt_i,
  input wire logic                      trigger_input_i,
  input wire logic                      brake_valid_i,
  input wire logic                      irq_o,
  input wire terg_pkg::terg_event_t     dma_req_o
);
  logic [15:0] en;
  logic        w;
  assign w = bus_i.wr && bus_i.addr == TERG_OFS_EN;
  // Shadow of the enable register
  always_ff @(posedge clk_i or negedge rstn_i)
    if (!rstn_i) en <= 16'h0000;
    else if (w) en <= bus_i.wdata & TERG_EN_MASK;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  a_upd_dma_on: assert property (evt_i.update && en[8] && !w
    |=> dma_req_o.update) else $error("update dma missing");
  a_ch_dma_gate: assert property (!w
    |=> dma_req_o.ch == $past(evt_i.ch & en[12:9])) else $error("ch dma");
  a_trig_dma_on: assert property ($rose(trigger_input_i) && en[14]
    && !w |=> dma_req_o.trig) else $error("trig dma missing");
  a_trig_dma_off: assert property (!en[14] && !w
    |=> !dma_req_o.trig) else $error("trig dma unmasked");
  a_brake_irq: assert property (brake_valid_i && en[7] && !w
    |=> irq_o) else $error("brake irq missing");
  a_irq_masked: assert property (en[7:0] == 8'h00 && !w
    |=> !irq_o) else $error("irq unmasked");
  a_rd_enable: assert property (bus_i.rd && bus_i.addr == TERG_OFS_EN
    |=> rdata_o == en) else $error("enable readback");
  a_stat_resv: assert property (
    bus_i.rd && bus_i.addr == TERG_OFS_STAT
    |=> rdata_o[15:13] == 3'h0 && !rdata_o[8])
    else $error("reserved status bits");
endmodule
bind terg_gating terg_checker chk_i (.clk_i(clk_i), .rstn_i(rstn_i),
  .bus_i(bus_i), .rdata_o(rdata_o), .evt_i(evt_i),
  .trigger_input_i(trigger_input_i), .brake_valid_i(brake_valid_i),
  .irq_o(irq_o), .dma_req_o(dma_req_o));

/* File: test/terg_gating_tb.sv */
// Self-checking bench of the event request gating block
`timescale 1ns/10ps
module terg_gating_tb;
  import terg_pkg::*;
  logic             clk_i = 0, rstn_i = 0, trg = 0, brk = 0, irq;
  terg_bus_req_t    bus = '0;
  terg_event_t      evt = '0, dma, e;
  logic [3:0]       im = 4'h0, cr = 4'h0;
  terg_slave_mode_t sm = TERG_SM_OFF;
  logic [15:0]      rq, v;
  int n_fail = 0, check_count = 0, seed = 35975, cyc = 0, n_upd, k, ne;
  always #20 clk_i = ~clk_i;
  terg_gating dut (.clk_i(clk_i), .rstn_i(rstn_i), .bus_i(bus),
    .rdata_o(rq), .evt_i(evt), .ch_input_mode_i(im), .cap_read_i(cr),
    .trigger_input_i(trg), .slave_mode_i(sm), .brake_valid_i(brk),
    .irq_o(irq), .dma_req_o(dma));
  terg_sink sink (.clk_i(clk_i), .req_i(dma), .n_upd_o(n_upd));
  task stop_test;
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] s, input logic [15:0] x);
    check_count++;
    if (s !== x) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, x, s);
    end
  endtask
  function logic [15:0] en_exp(input logic [15:0] d);
    return d & TERG_EN_MASK;
  endfunction
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_i) bus.wr <= 1'b0;
    #1;
  endtask
  task rd(input logic [7:0] a, input logic [15:0] x, input string nm);
    @(posedge clk_i) bus <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk_i) bus.rd <= 1'b0;
    #1 chk(nm, rq, x);
  endtask
  task ev(input terg_event_t d);
    @(posedge clk_i) evt <= d;
    @(posedge clk_i) evt <= '0;
    #1;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      stop_test;
    end
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd(TERG_OFS_EN, 16'h0000, "en_rst");
    rd(TERG_OFS_STAT, 16'h0000, "st_rst");
    for (k = 0; k < 8; k++) begin
      v = 16'($random(seed));
      wr(TERG_OFS_EN, v);
      wr(8'h14, 16'hFFFF);
      rd(8'h14, 16'h0000, "unmapped");
      rd(TERG_OFS_EN, en_exp(v), "en_rw");
    end
    wr(TERG_OFS_EN, 16'h7FFF);
    ev(7'h01);
    chk("upd_dma", 16'(dma), 16'h0001);
    chk("upd_irq", 16'(irq), 16'h0001);
    wr(TERG_OFS_STAT, 16'hFFFF);
    rd(TERG_OFS_STAT, 16'h0001, "w1_keep");
    wr(TERG_OFS_STAT, 16'h0000);
    chk("irq_clr", 16'(irq), 16'h0000);
    @(posedge clk_i) im <= 4'hF;
    ev(7'h1E);
    ev(7'h1E);
    chk("ch_dma", 16'(dma), 16'h001E);
    rd(TERG_OFS_STAT, 16'h1E1E, "ovc");
    @(posedge clk_i) cr <= 4'h1;
    @(posedge clk_i) cr <= 4'h0;
    rd(TERG_OFS_STAT, 16'h1E1C, "cap_rd");
    wr(TERG_OFS_STAT, 16'h0000);
    @(posedge clk_i) im <= 4'h0;
    ev(7'h02);
    ev(7'h02);
    rd(TERG_OFS_STAT, 16'h0002, "out_no_ovc");
    wr(TERG_OFS_STAT, 16'h0000);
    ev(7'h20);
    chk("com_dma", 16'(dma), 16'h0020);
    @(posedge clk_i) brk <= 1'b1;
    @(posedge clk_i) brk <= 1'b0;
    rd(TERG_OFS_STAT, 16'h00A0, "com_brk");
    wr(TERG_OFS_STAT, 16'h0000);
    @(posedge clk_i) trg <= 1'b1;
    @(posedge clk_i) #1 chk("trg_dma", 16'(dma), 16'h0040);
    rd(TERG_OFS_STAT, 16'h0040, "trg_rise");
    wr(TERG_OFS_STAT, 16'h0000);
    @(posedge clk_i) trg <= 1'b0;
    rd(TERG_OFS_STAT, 16'h0000, "trg_fall");
    @(posedge clk_i) trg <= 1'b1;
    sm <= TERG_SM_GATED;
    repeat (2) @(posedge clk_i);
    wr(TERG_OFS_STAT, 16'h0000);
    @(posedge clk_i) trg <= 1'b0;
    rd(TERG_OFS_STAT, 16'h0040, "gated_fall");
    wr(TERG_OFS_EN, 16'h0000);
    ev(7'h01);
    chk("dma_off", 16'(dma), 16'h0000);
    chk("irq_off", 16'(irq), 16'h0000);
    wr(TERG_OFS_EN, 16'h0001);
    chk("irq_on", 16'(irq), 16'h0001);
    wr(TERG_OFS_EN, 16'h7FFF);
    ne = n_upd;
    for (k = 0; k < 200; k++) begin
      e = 7'($random(seed));
      @(posedge clk_i) evt <= e;
      ne += e.update;
      brk <= e.commut;
    end
    @(posedge clk_i) evt <= '0;
    brk <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("upd_count", 16'(n_upd), 16'(ne));
    stop_test;
  end
endmodule
